// ==== rtl/wsr_count_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// one-shot counter: counts advances up to limit, then one expired pulse
module wsr_count_timer #(
    parameter int unsigned WIDTH = 22
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic advance,
    input wire logic [WIDTH-1:0] limit,
    output logic expired
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt; // advances seen so far
        logic expired;         // one-cycle pulse
    } wsr_timer_t;
    wsr_timer_t r_ff;
    wsr_timer_t nxt_r;
    logic [WIDTH-1:0] cnt_plus;
    assign cnt_plus = r_ff.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    // count, wrap to zero at terminal count
    always_comb begin
        nxt_r = r_ff;
        nxt_r.expired = 1'b0;
        if (clear) begin
            nxt_r.cnt = '0;
        end else if (advance) begin
            if (cnt_plus >= limit) begin
                // zero restarts the chain so one time-out gives one pulse
                nxt_r.cnt = '0;
                nxt_r.expired = 1'b1;
            end else begin
                nxt_r.cnt = cnt_plus;
            end
        end
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
    assign expired = r_ff.expired;
endmodule
`default_nettype wire

// ==== rtl/wsr_guard_top.sv ====
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// guard timer, stop-wake bookkeeping and reset sequencing behind an avalon slave
module wsr_guard_top #(
    parameter int unsigned RC_TICKS_0 = wsr_pkg::RC_CYCLES_0,
    parameter int unsigned RC_TICKS_1 = wsr_pkg::RC_CYCLES_1,
    parameter int unsigned RC_TICKS_2 = wsr_pkg::RC_CYCLES_2,
    parameter int unsigned RC_TICKS_3 = wsr_pkg::RC_CYCLES_3,
    parameter int unsigned POR_DELAY = wsr_pkg::POR_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave, word addressed
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // core events, one-cycle pulses on clk
    input wire logic refresh_instr,
    input wire logic halt_entry,
    input wire logic halt_exit,
    input wire logic stop_entry,
    // pins from outside the clock domain
    input wire logic [7:0] port2_in,
    input wire logic [2:0] port3_in,
    input wire logic crystal_in_pin,
    input wire logic supply_ok,
    // fuse options, static levels, and the test mode request
    input wire logic opt_permanent_guard,
    input wire logic opt_test_disable,
    input wire logic test_mode_req,
    // outputs
    output logic core_reset,
    output logic peripheral_reset,
    output logic stop_recovered,
    output logic flag_update,
    output logic crystal_keep_alive,
    output logic test_mode_grant
);
    localparam int unsigned TW = 22; // fits 100 ms at 20 MHz
    localparam int unsigned DW = 16; // reset delay counter width

    // all register state of this block
    typedef struct packed {
        logic ack;                 // bus answer cycle
        logic [31:0] rdata;        // registered read data
        wsr_pkg::wsr_mode_t mode;  // run, halt, stop
        logic warm;                // cold/warm start flag
        logic [6:0] swc;           // stop_wake_control bits 6..0
        logic [1:0] sws2;          // stop_wake_source_2 source field
        logic [4:0] gtm;           // guard_timer_mode bits 4..0
        logic guard_on;            // enabled by first refresh
        logic delay_active;        // reset delay one-shot running
        logic core_reset;          // reset to the core
        logic [6:0] win_cnt;       // write window remaining
        logic xtal_last;           // crystal level last cycle
        logic supply_last;         // supply level last cycle
        logic periph_rst;          // pulse to port/config registers
        logic recovered;           // pulse on stop recovery
        logic flag_upd;            // pulse to core flag logic
        logic test_lock;           // test-disable caught for good
    } wsr_core_state_t;

    wsr_core_state_t r_ff;
    wsr_core_state_t nxt_r;

    // synchronised pins: port2, port3, crystal, supply
    logic [12:0] pins_s;
    logic [7:0] p2_s;
    logic [2:0] p3_s;
    logic xtal_s;
    logic supply_s;
    logic guard_expired;
    logic delay_expired;
    logic [TW-1:0] guard_limit;
    logic bus_req;
    logic wr_take;
    logic win_open;
    logic in_stop;
    logic in_halt;
    logic guard_enabled;
    logic guard_tick;
    logic guard_gate;
    logic guard_clear;
    logic [1:0] wake_sel;
    logic wake_hit;
    logic delay_trig;
    logic supply_rise;

    // address match, used by both read and write paths
    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] idx);
        reg_hit = (addr == idx);
    endfunction

    // picks the wake level: {valid, level}; primary wins over secondary
    function automatic logic [1:0] wake_select(input logic [2:0] src1, input logic [1:0] src2,
                                               input logic [7:0] p2, input logic [2:0] p3);
        logic [1:0] res;
        res = 2'b00;
        if (src1 != wsr_pkg::SRC1_NONE) begin
            // software should have left the secondary field at zero
            unique case (src1)
                wsr_pkg::SRC1_P31: res = {1'b1, p3[0]};
                wsr_pkg::SRC1_P32: res = {1'b1, p3[1]};
                wsr_pkg::SRC1_P33: res = {1'b1, p3[2]};
                wsr_pkg::SRC1_P27: res = {1'b1, p2[7]};
                wsr_pkg::SRC1_NOR_LOW: res = {1'b1, ~|p2[3:0]};
                wsr_pkg::SRC1_NOR_ALL: res = {1'b1, ~|p2};
                default: res = 2'b00; // reserved code wakes nothing
            endcase
        end else begin
            unique case (src2)
                wsr_pkg::SRC2_AND_LOW: res = {1'b1, &p2[3:0]};
                wsr_pkg::SRC2_AND_ALL: res = {1'b1, &p2};
                default: res = 2'b00; // none: only power-up or external reset
            endcase
        end
        wake_select = res;
    endfunction

    // port, crystal and supply levels pass four flops: three synchroniser stages and the filtered output flop
    wsr_pin_sync #(
        .WIDTH(13)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({supply_ok, crystal_in_pin, port3_in, port2_in}),
        .q(pins_s)
    );
    assign p2_s = pins_s[7:0];
    assign p3_s = pins_s[10:8];
    assign xtal_s = pins_s[11];
    assign supply_s = pins_s[12];

    // bus handshake: one wait cycle, then the answer
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~r_ff.ack;
    assign wr_take = avs_write & r_ff.ack & avs_byteenable[0];
    assign avs_readdata = r_ff.rdata;

    // mode register only opens for a short time after each restart
    assign win_open = (r_ff.win_cnt != 7'h00) & ~r_ff.core_reset;

    assign in_stop = (r_ff.mode == wsr_pkg::MODE_STOP);
    assign in_halt = (r_ff.mode == wsr_pkg::MODE_HALT);

    // permanent fuse keeps the guard on without a refresh
    assign guard_enabled = r_ff.guard_on | opt_permanent_guard;

    // crystal edges only arrive while the oscillator runs, so a halted crystal freezes the count
    assign guard_tick = r_ff.gtm[wsr_pkg::GTM_CLKSEL_BIT] ? (xtal_s & ~r_ff.xtal_last) : 1'b1;

    // activity gating by mode; the fuse overrides the halt and stop bits
    assign guard_gate = guard_enabled
                      & (r_ff.mode == wsr_pkg::MODE_RUN
                         | (in_halt & (r_ff.gtm[wsr_pkg::GTM_HALT_BIT] | opt_permanent_guard))
                         | (in_stop & (r_ff.gtm[wsr_pkg::GTM_STOP_BIT] | opt_permanent_guard)));

    // refresh and reset restart the chain
    assign guard_clear = refresh_instr | r_ff.core_reset | ~guard_enabled;

    // time select, crystal ticks or RC-equivalent system clocks
    always_comb begin
        guard_limit = TW'(RC_TICKS_0);
        unique case ({r_ff.gtm[wsr_pkg::GTM_CLKSEL_BIT], r_ff.gtm[1:0]})
            3'b000: guard_limit = TW'(RC_TICKS_0);
            3'b001: guard_limit = TW'(RC_TICKS_1);
            3'b010: guard_limit = TW'(RC_TICKS_2);
            3'b011: guard_limit = TW'(RC_TICKS_3);
            3'b100: guard_limit = TW'(wsr_pkg::XTAL_TICKS_0);
            3'b101: guard_limit = TW'(wsr_pkg::XTAL_TICKS_1);
            3'b110: guard_limit = TW'(wsr_pkg::XTAL_TICKS_2);
            3'b111: guard_limit = TW'(wsr_pkg::XTAL_TICKS_3);
        endcase
    end

    // the guard one-shot itself
    wsr_count_timer #(
        .WIDTH(TW)
    ) u_guard_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clear(guard_clear),
        .advance(guard_gate & guard_tick),
        .limit(guard_limit),
        .expired(guard_expired)
    );

    // wake level compared against the polarity bit for either source register
    assign wake_sel = wake_select(r_ff.swc[wsr_pkg::SWC_SRC_LSB +: 3], r_ff.sws2, p2_s, p3_s);
    assign wake_hit = in_stop & wake_sel[1]
                    & (wake_sel[0] == r_ff.swc[wsr_pkg::SWC_POL_BIT]);

    // delay triggers: power good, recovery with delay bit, guard time-out
    assign supply_rise = supply_s & ~r_ff.supply_last;
    assign delay_trig = supply_rise
                      | (wake_hit & r_ff.swc[wsr_pkg::SWC_DELAY_BIT])
                      | guard_expired;

    // reset delay one-shot, held cleared while supply is low
    wsr_count_timer #(
        .WIDTH(DW)
    ) u_delay_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clear(delay_trig | ~r_ff.delay_active | ~supply_s),
        .advance(r_ff.delay_active),
        .limit(DW'(POR_DELAY)),
        .expired(delay_expired)
    );

    // next-state logic
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ack = bus_req & ~r_ff.ack;
        nxt_r.xtal_last = xtal_s;
        nxt_r.supply_last = supply_s;
        nxt_r.periph_rst = 1'b0;
        nxt_r.recovered = 1'b0;
        // every refresh tells the core to update its condition flags
        nxt_r.flag_upd = refresh_instr;
        // fuse caught by a clock, once seen never released
        nxt_r.test_lock = r_ff.test_lock | opt_test_disable;

        // read data prepared in the wait cycle so it stands at the answer
        if (bus_req & ~r_ff.ack & avs_read) begin
            nxt_r.rdata = 32'h0000_0000;
            if (reg_hit(avs_address, wsr_pkg::IDX_STOP_WAKE_CONTROL)) begin
                // only the flag reads back, the rest is write-only
                nxt_r.rdata[wsr_pkg::SWC_WARM_BIT] = r_ff.warm;
            end else if (reg_hit(avs_address, wsr_pkg::IDX_GUARD_STATUS)) begin
                nxt_r.rdata[6:0] = {r_ff.test_lock, in_halt, r_ff.delay_active, in_stop,
                                    r_ff.warm, win_open, guard_enabled};
            end
            // mode register and unmapped indices read zero
        end

        // register writes
        if (wr_take & reg_hit(avs_address, wsr_pkg::IDX_STOP_WAKE_CONTROL)) begin
            nxt_r.swc = avs_writedata[6:0];
        end
        if (wr_take & reg_hit(avs_address, wsr_pkg::IDX_STOP_WAKE_SOURCE_2)) begin
            nxt_r.sws2 = avs_writedata[wsr_pkg::SWS2_SRC_LSB +: 2];
        end
        if (wr_take & reg_hit(avs_address, wsr_pkg::IDX_GUARD_TIMER_MODE) & win_open) begin
            // bits 7..5 are dropped, they steer nothing
            nxt_r.gtm = avs_writedata[4:0];
        end

        // window counts down once opened
        if (r_ff.win_cnt != 7'h00) begin
            nxt_r.win_cnt = r_ff.win_cnt - 7'h01;
        end

        // first refresh enables the guard
        if (refresh_instr & ~r_ff.core_reset) begin
            nxt_r.guard_on = 1'b1;
        end

        // core power modes
        if (halt_entry) begin
            nxt_r.mode = wsr_pkg::MODE_HALT;
        end
        if (halt_exit & in_halt) begin
            nxt_r.mode = wsr_pkg::MODE_RUN;
        end

        // stop recovery by a wake source
        if (wake_hit) begin
            nxt_r.mode = wsr_pkg::MODE_RUN;
            nxt_r.recovered = 1'b1;
            nxt_r.swc[wsr_pkg::SWC_DIV16_BIT] = 1'b0;
            if (!r_ff.swc[wsr_pkg::SWC_DELAY_BIT]) begin
                // no delay: the window restarts at once
                nxt_r.win_cnt = wsr_pkg::WINDOW_CYCLES;
            end
        end

        // guard time-out
        if (guard_expired) begin
            nxt_r.guard_on = 1'b0;
            nxt_r.mode = wsr_pkg::MODE_RUN;
            if (!in_stop) begin
                // outside stop the configuration goes back to defaults
                nxt_r.swc = wsr_pkg::SWC_RESET;
                nxt_r.sws2 = wsr_pkg::SWS2_RESET;
                nxt_r.gtm = wsr_pkg::GTM_RESET;
                nxt_r.periph_rst = 1'b1;
                nxt_r.warm = 1'b0;
            end
            // in stop configuration and flag are kept
        end

        // reset delay one-shot
        if (delay_trig) begin
            nxt_r.delay_active = 1'b1;
        end else if (delay_expired) begin
            nxt_r.delay_active = 1'b0;
        end

        // low supply is a full power-up reset
        if (!supply_s) begin
            nxt_r.delay_active = 1'b1;
            nxt_r.mode = wsr_pkg::MODE_RUN;
            nxt_r.guard_on = 1'b0;
            nxt_r.swc = wsr_pkg::SWC_RESET;
            nxt_r.sws2 = wsr_pkg::SWS2_RESET;
            nxt_r.gtm = wsr_pkg::GTM_RESET;
            nxt_r.warm = 1'b0;
            // one pulse as the supply falls, not a level while it stays low
            nxt_r.periph_rst = r_ff.supply_last;
        end

        // core reset held while supply is low or the delay runs
        nxt_r.core_reset = ~supply_s | nxt_r.delay_active;
        // window opens when the core leaves reset
        if (r_ff.core_reset & ~nxt_r.core_reset) begin
            nxt_r.win_cnt = wsr_pkg::WINDOW_CYCLES;
        end
        if (nxt_r.core_reset) begin
            nxt_r.guard_on = 1'b0;
        end

        // stop entry sets the flag last, so it wins over any clear
        if (stop_entry & ~r_ff.core_reset) begin
            nxt_r.mode = wsr_pkg::MODE_STOP;
            nxt_r.warm = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff.ack <= 1'b0;
            r_ff.rdata <= 32'h0000_0000;
            r_ff.mode <= wsr_pkg::MODE_RUN;
            r_ff.warm <= 1'b0;
            r_ff.swc <= wsr_pkg::SWC_RESET;
            r_ff.sws2 <= wsr_pkg::SWS2_RESET;
            r_ff.gtm <= wsr_pkg::GTM_RESET;
            r_ff.guard_on <= 1'b0;
            r_ff.delay_active <= 1'b1;
            r_ff.core_reset <= 1'b1;
            r_ff.win_cnt <= 7'h00;
            r_ff.xtal_last <= 1'b0;
            r_ff.supply_last <= 1'b0;
            r_ff.periph_rst <= 1'b0;
            r_ff.recovered <= 1'b0;
            r_ff.flag_upd <= 1'b0;
            r_ff.test_lock <= 1'b0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs
    assign core_reset = r_ff.core_reset;
    assign peripheral_reset = r_ff.periph_rst;
    assign stop_recovered = r_ff.recovered;
    assign flag_update = r_ff.flag_upd;
    // keeps the crystal alive in stop for the guard alone
    assign crystal_keep_alive = in_stop & r_ff.gtm[wsr_pkg::GTM_STOP_BIT]
                              & r_ff.gtm[wsr_pkg::GTM_CLKSEL_BIT];
    // refused for good once the fuse has been seen
    assign test_mode_grant = test_mode_req & ~r_ff.test_lock & ~opt_test_disable;
endmodule
`default_nettype wire

// ==== rtl/wsr_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage pin synchroniser; output moves only when stages two and three agree
module wsr_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1; // first stage, read only by s2
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } wsr_sync_t;
    wsr_sync_t r_ff;
    wsr_sync_t nxt_r;
    // shift and filter
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = din;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        // agreeing bits take the new level, others hold
        nxt_r.q = (~(r_ff.s2 ^ r_ff.s3) & r_ff.s2) | ((r_ff.s2 ^ r_ff.s3) & r_ff.q);
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
    assign q = r_ff.q;
endmodule
`default_nettype wire

// ==== rtl/wsr_pkg.sv ====
// What this block does
// - entering stop sets the warm-start flag
// - guard reset during stop keeps flag at one
// - secondary source: none, and of 0-3, and of 0-7
// - retriggerable one-shot, first refresh enables it
// - refresh instruction updates zero, sign, overflow flags
// - mode register writable only 60 clocks after restart
// - mode register write-only at index 0x0F
// - stop time-out keeps configuration, still delays reset
// - time select picks 256/512/1024/4096 or RC times
// - halt bit keeps guard counting in halt
// - stop bit keeps guard counting in stop
// - stop and crystal bits keep crystal for guard
// - clock select: crystal pin or on-board RC
// - halted crystal in stop never advances guard
// - permanent option overrides halt and stop bits in guard gating, not in crystal keep-alive
// - mode register bits 7 to 5 do nothing
// - reset held while supply below threshold
// - test-disable fuse refuses test mode forever
// - reset delay triggered by power-good, recovery, time-out
// - polarity bit applies to both source registers
package wsr_pkg;
    // clock and bus geometry
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned ADDR_W = 5;
    // register indices, byte address is four times these
    localparam logic [4:0] IDX_STOP_WAKE_CONTROL = 5'h0B;
    localparam logic [4:0] IDX_STOP_WAKE_SOURCE_2 = 5'h0D;
    localparam logic [4:0] IDX_GUARD_TIMER_MODE = 5'h0F;
    localparam logic [4:0] IDX_GUARD_STATUS = 5'h10;
    // stop_wake_control fields
    localparam int unsigned SWC_WARM_BIT = 7;
    localparam int unsigned SWC_POL_BIT = 6;
    localparam int unsigned SWC_DELAY_BIT = 5;
    localparam int unsigned SWC_SRC_LSB = 2;
    localparam int unsigned SWC_DIV16_BIT = 0;
    localparam logic [6:0] SWC_RESET = 7'h20;
    // stop_wake_source_2 fields
    localparam int unsigned SWS2_SRC_LSB = 0;
    localparam logic [1:0] SWS2_RESET = 2'h0;
    // guard_timer_mode fields, bits 7..5 are never stored
    localparam int unsigned GTM_TSEL_LSB = 0;
    localparam int unsigned GTM_HALT_BIT = 2;
    localparam int unsigned GTM_STOP_BIT = 3;
    localparam int unsigned GTM_CLKSEL_BIT = 4;
    localparam logic [4:0] GTM_RESET = 5'h0C;
    // write window after each restart, in system clocks
    localparam logic [6:0] WINDOW_CYCLES = 7'h3C;
    // crystal-clocked time-outs in crystal ticks
    localparam int unsigned XTAL_TICKS_0 = 256;
    localparam int unsigned XTAL_TICKS_1 = 512;
    localparam int unsigned XTAL_TICKS_2 = 1024;
    localparam int unsigned XTAL_TICKS_3 = 4096;
    // RC time-outs in ns, minimum times, so cycle counts round up
    localparam longint unsigned RC_TIME_NS_0 = 6_250_000;
    localparam longint unsigned RC_TIME_NS_1 = 12_500_000;
    localparam longint unsigned RC_TIME_NS_2 = 25_000_000;
    localparam longint unsigned RC_TIME_NS_3 = 100_000_000;
    localparam int unsigned RC_CYCLES_0 = int'((RC_TIME_NS_0 * CLK_HZ + 999_999_999) / 1_000_000_000);
    localparam int unsigned RC_CYCLES_1 = int'((RC_TIME_NS_1 * CLK_HZ + 999_999_999) / 1_000_000_000);
    localparam int unsigned RC_CYCLES_2 = int'((RC_TIME_NS_2 * CLK_HZ + 999_999_999) / 1_000_000_000);
    localparam int unsigned RC_CYCLES_3 = int'((RC_TIME_NS_3 * CLK_HZ + 999_999_999) / 1_000_000_000);
    // reset delay length, no figure given, plain default
    localparam int unsigned POR_DELAY_CYCLES = 16;
    // primary source codes
    localparam logic [2:0] SRC1_NONE = 3'h0;
    localparam logic [2:0] SRC1_P31 = 3'h2;
    localparam logic [2:0] SRC1_P32 = 3'h3;
    localparam logic [2:0] SRC1_P33 = 3'h4;
    localparam logic [2:0] SRC1_P27 = 3'h5;
    localparam logic [2:0] SRC1_NOR_LOW = 3'h6;
    localparam logic [2:0] SRC1_NOR_ALL = 3'h7;
    // secondary source codes
    localparam logic [1:0] SRC2_NONE = 2'h0;
    localparam logic [1:0] SRC2_AND_LOW = 2'h1;
    localparam logic [1:0] SRC2_AND_ALL = 2'h2;
    // power mode of the core
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10
    } wsr_mode_t;
endpackage

// ==== test/watchdog_stop_recovery_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, s); end end
// bench: register table, retrigger, lock, time-out, stop, fuse, supply
module watchdog_stop_recovery_tb_top;
    typedef struct packed {logic [4:0] a; logic [7:0] m; logic [7:0] e;} wsr_row_t;
    logic clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, want_refresh = 1'h0, want_stop = 1'h0;
    logic halt_entry = 1'h0, halt_exit = 1'h0, crystal_in_pin = 1'h0, supply_ok = 1'h1, test_mode_req = 1'h0;
    logic opt_permanent_guard = 1'h0, opt_test_disable = 1'h0, refresh_instr, stop_entry, avs_waitrequest;
    logic core_reset, peripheral_reset, stop_recovered, flag_update, crystal_keep_alive, test_mode_grant;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic [7:0] port2_in = 8'h00, q;
    logic [2:0] port3_in = 3'h0;
    int bad_count = 0, checked = 0, cyc = 0, n;
    // address, mask, expected: write-only places, unmapped, status, cold flag
    wsr_row_t rows [5] = '{'{5'h0F, 8'hFF, 8'h00}, '{5'h1F, 8'hFF, 8'h00}, '{5'h0D, 8'hFF, 8'h00},
        '{5'h10, 8'h03, 8'h02}, '{5'h0B, 8'h80, 8'h00}};
    // short rc counts keep the time-outs between 20 and 160 cycles
    wsr_guard_top #(.RC_TICKS_0(20), .RC_TICKS_1(40), .RC_TICKS_2(80), .RC_TICKS_3(160)) dut (.*);
    wsr_core_model model (.*);
    always #25 clk = ~clk;
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, d};
        // look between edges, where waitrequest has settled
        do @(negedge clk); while (avs_waitrequest !== 1'h0);
        @(posedge clk);
        rd = avs_readdata[7:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    // one-cycle request to the core model: refresh or stop
    task automatic pulse(input logic stop);
        @(posedge clk);
        if (stop) want_stop <= 1'h1;
        else want_refresh <= 1'h1;
        @(posedge clk);
        want_stop <= 1'h0;
        want_refresh <= 1'h0;
    endtask
    task automatic results();
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: the sequence needs well under 1500 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1500) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        while (core_reset !== 1'h0) @(negedge clk);
        bus(1'h1, 5'h0F, 8'hED, q); // reserved bits set, select RC count 1, 40 cycles here
        for (int i = 0; i < 5; i++) `CHK("table", 8'h00, q & rows[i].m) // write gives no data
        for (int i = 0; i < 5; i++) begin
            bus(1'h0, rows[i].a, 8'h00, q);
            `CHK("table", rows[i].e, q & rows[i].m)
        end
        for (int k = 0; k < 4; k++) begin
            pulse(1'h0);
            repeat (28) @(posedge clk);
        end
        `CHK("alive", 1'h0, core_reset)
        bus(1'h0, 5'h10, 8'h00, q);
        `CHK("status", 8'h01, q & 8'h03)
        bus(1'h1, 5'h0F, 8'h0C, q); // late write, must be dropped
        pulse(1'h0);
        n = 0;
        while (core_reset !== 1'h1) begin
            @(negedge clk);
            n++;
        end
        `CHK("timeout", 1'h1, n >= 40 && n <= 48)
        while (core_reset !== 1'h0) @(negedge clk);
        bus(1'h0, 5'h0B, 8'h00, q);
        `CHK("cold", 8'h00, q & 8'h80)
        pulse(1'h1);
        bus(1'h0, 5'h0B, 8'h00, q);
        `CHK("warm", 8'h80, q & 8'h80)
        bus(1'h1, 5'h0B, 8'h60, q); // high level wakes, delay on, primary source zero
        bus(1'h1, 5'h0D, 8'h01, q); // wake on and of port2 bits 3..0
        port2_in <= 8'h0F;
        n = 0;
        while (stop_recovered !== 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK("wake", 1'h1, stop_recovered)
        test_mode_req <= 1'h1;
        @(posedge clk);
        @(posedge clk);
        `CHK("grant", 1'h1, test_mode_grant)
        opt_test_disable <= 1'h1;
        @(posedge clk);
        opt_test_disable <= 1'h0;
        repeat (2) @(posedge clk);
        `CHK("locked", 1'h0, test_mode_grant)
        supply_ok <= 1'h0;
        repeat (8) @(posedge clk);
        `CHK("supply", 1'h1, core_reset)
        results();
    end
endmodule
`default_nettype wire

// ==== test/wsr_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// core side: turns bench requests into one-cycle instruction pulses
module wsr_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic want_refresh,
    input wire logic want_stop,
    output logic refresh_instr,
    output logic stop_entry
);
    // pulses launched one edge after the request, silent in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_instr <= 1'h0;
            stop_entry <= 1'h0;
        end else begin
            refresh_instr <= want_refresh;
            stop_entry <= want_stop;
        end
    end
endmodule
`default_nettype wire

// ==== test/wsr_guard_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// bus, refresh, fuse and reset relations seen at the top ports
module wsr_guard_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic refresh_instr,
    input wire logic supply_ok,
    input wire logic opt_test_disable,
    input wire logic test_mode_req,
    input wire logic core_reset,
    input wire logic peripheral_reset,
    input wire logic flag_update,
    input wire logic test_mode_grant
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // supply low long enough to cross the pin synchroniser and the reset flop
    sequence low_supply_s; !supply_ok [*6]; endsequence
    // request still held off by the slave
    sequence held_req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
    AST_ONE_WAIT: assert property (held_req_s |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    AST_MODE_NO_READ: assert property (avs_read && !avs_waitrequest && avs_address == 5'h0F |-> avs_readdata == '0)
        else $error("mode register gave read data");
    AST_FLAG_AFTER: assert property (refresh_instr |=> flag_update)
        else $error("refresh without flag update");
    AST_FLAG_CAUSE: assert property (flag_update |-> $past(refresh_instr))
        else $error("flag update without refresh");
    AST_LOW_SUPPLY: assert property (low_supply_s |-> core_reset)
        else $error("core runs on low supply");
    AST_FUSE_BLOCK: assert property (opt_test_disable |-> !test_mode_grant)
        else $error("test mode granted with fuse");
    AST_GRANT_CAUSE: assert property (test_mode_grant |-> test_mode_req)
        else $error("test mode granted unasked");
    AST_ONE_PULSE: assert property (peripheral_reset |=> !peripheral_reset)
        else $error("peripheral reset longer than a pulse");
endmodule
bind wsr_guard_top wsr_guard_properties u_props (.*);
`default_nettype wire
